// ==== logic/mcu_data_transfer_arith_unit.sv ====
// data-transfer and arithmetic datapath of an 8-bit controller
// assumes a classic wishbone master on the one clock and synchronous inputs
//
// Contract
// - zero flag is one when an affecting result is zero, else cleared.
// - carry flag holds unsigned carry for adds, borrow for subtracts.
// - nibble carry flag set on carry out of low nibble.
// - overflow flag set when signed result leaves the byte range.
// - single-bit memory operations reach only bytes 0 to 0x3F.
// - memory to working register: one cycle, only zero flag updated.
// - io register to working register: one cycle, only zero flag.
// - timer word load and store move 16 bits, one cycle, no flags.
// - indirect move through a pointer word takes two cycles, no flags.
// - exchange working register with memory byte, one cycle, no flags.
// - push stores flags and working register, stack pointer plus two.
// - pop lowers stack pointer by two, reloads flags and register.
// - add forms write sum to register or memory, all four flags.
// - add-with-carry forms also add the carry flag in.
// - negate-then-add adds the destination's negation to the other operand.
// - subtract is addition of the two's complement, all four flags.
// - subtract-with-borrow forms also subtract the carry flag.
// - increment and decrement of memory, one cycle, all four flags.
`include "dta_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mcu_data_transfer_arith_unit #(
  parameter int DMEM_AW = 8,
  parameter int IO_AW = 5
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [11:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // status
  output logic BUSY_OUT,
  output logic [3:0] FLAGS_OUT
);

  ////////////////////////////////////////////////////////////////////
  // reset release and state

  logic rst_q1, rst_n;
  dta_pkg::wb_req_s req;
  dta_pkg::state_e state, next_state;
  dta_pkg::op_e op, next_op;
  logic [7:0] acc, next_acc, sp, next_sp, ptr, next_ptr;
  logic [3:0] flag, next_flag;
  logic [15:0] tmr, next_tmr;
  logic [18:0] oper, next_oper;
  logic err, next_err, next_ack, next_busy;
  logic [31:0] next_dat, merged;
  logic [7:0] dmem [2**DMEM_AW];
  logic [7:0] iomem [2**IO_AW];
  // two write ports so push and timer load land in one cycle
  logic wa_en, wb_en, io_en;
  logic [DMEM_AW-1:0] wa_adr, wb_adr, ma;
  logic [7:0] wa_dat, wb_dat, io_dat, m, imm;
  logic [IO_AW-1:0] io_adr;
  logic bus_wr;
  dta_pkg::alu_s r;

  // release reset through two stages
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // adder shared by every arithmetic form

  // sub computes a - b - ci as a + ~b + ~ci, carry out inverted to borrow
  function automatic dta_pkg::alu_s alu(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci, input logic sub);
    logic [7:0] bx;
    logic [8:0] s;
    logic [4:0] n;
    logic c0;
    bx = sub ? ~b : b;
    c0 = sub ? ~ci : ci;
    s = {1'b0, a} + {1'b0, bx} + {8'h00, c0};
    n = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, c0};
    alu.res = s[7:0];
    alu.z = (s[7:0] == 8'h00);
    alu.c = s[8] ^ sub;
    alu.ac = n[4] ^ sub;
    alu.ov = (a[7] == bx[7]) && (s[7] != a[7]);
  endfunction : alu

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lanes[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : lanes

  ////////////////////////////////////////////////////////////////////
  // next-value logic for bus, registers and execution

  assign req = '{WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ADR_IN, WB_SEL_IN, WB_DAT_IN};
  // a write takes effect at the edge where the master sees ack
  assign bus_wr = req.cyc && req.stb && req.we && WB_ACK_OUT;
  assign ma = oper[DMEM_AW-1:0];
  assign m = dmem[ma];
  assign imm = oper[15:8];

  always_comb begin
    next_state = state;
    next_op = op;
    next_acc = acc;
    next_flag = flag;
    next_sp = sp;
    next_ptr = ptr;
    next_oper = oper;
    next_err = err;
    next_tmr = tmr + 16'h0001;
    wa_en = 1'b0;
    wb_en = 1'b0;
    io_en = 1'b0;
    wa_adr = req.adr[DMEM_AW+1:2];
    wb_adr = ma + 1'b1;
    wa_dat = req.dat[7:0];
    wb_dat = 8'h00;
    io_adr = req.adr[IO_AW+1:2];
    io_dat = req.dat[7:0];
    r = '0;
    merged = 32'h0;
    next_ack = req.cyc && req.stb && !WB_ACK_OUT;
    next_dat = 32'h0;
    // read data, unmapped reads give zero
    case (req.adr[11:10])
      `RGN_MEM: next_dat = {24'h0, dmem[req.adr[DMEM_AW+1:2]]};
      `RGN_IO: next_dat = {24'h0, iomem[req.adr[IO_AW+1:2]]};
      `RGN_REGS: begin
        case (req.adr)
          `REG_CTRL: next_dat = {22'h0, err, state != dta_pkg::ST_IDLE, 2'h0, op};
          `REG_OPER: next_dat = {13'h0, oper};
          `REG_ACC: next_dat = {24'h0, acc};
          `REG_FLAG: next_dat = {28'h0, flag};
          `REG_SP: next_dat = {24'h0, sp};
          `REG_TMR: next_dat = {16'h0, tmr};
          default: next_dat = 32'h0;
        endcase
      end
      default: next_dat = 32'h0;
    endcase
    // bus writes; execution below overrides them in the same cycle
    if (bus_wr) begin
      case (req.adr[11:10])
        `RGN_MEM: wa_en = req.sel[0];
        `RGN_IO: io_en = req.sel[0];
        `RGN_REGS: begin
          case (req.adr)
            `REG_OPER: begin
              merged = lanes({13'h0, oper}, req.dat, req.sel);
              next_oper = merged[18:0];
            end
            `REG_ACC: if (req.sel[0]) next_acc = req.dat[7:0];
            `REG_FLAG: if (req.sel[0]) next_flag = req.dat[3:0];
            `REG_SP: if (req.sel[0]) next_sp = req.dat[7:0];
            `REG_TMR: begin
              merged = lanes({16'h0, tmr}, req.dat, req.sel);
              next_tmr = merged[15:0];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    case (state)
      dta_pkg::ST_IDLE: begin
        // a start while busy is ignored, the op code stays as it was
        if (bus_wr && req.adr == `REG_CTRL && req.sel[0]) begin
          next_op = dta_pkg::op_e'(req.dat[5:0]);
          next_err = 1'b0;
          next_state = dta_pkg::ST_EXEC;
        end
      end
      dta_pkg::ST_EXEC: begin
        next_state = dta_pkg::ST_IDLE;
        wa_adr = ma;
        io_adr = oper[IO_AW-1:0];
        // untouched flags simply keep next_flag = flag
        case (op)
          dta_pkg::MOV_A_I: next_acc = imm;
          dta_pkg::MOV_M_A: begin
            wa_en = 1'b1;
            wa_dat = acc;
          end
          dta_pkg::MOV_A_M: begin
            next_acc = m;
            next_flag[`FLG_Z] = (m == 8'h00);
          end
          dta_pkg::MOV_A_IO: begin
            next_acc = iomem[io_adr];
            next_flag[`FLG_Z] = (iomem[io_adr] == 8'h00);
          end
          dta_pkg::MOV_IO_A: begin
            io_en = 1'b1;
            io_dat = acc;
          end
          dta_pkg::TIMER_SNAPSHOT_LOAD: begin
            // low byte at the word address, high byte above
            {wb_en, wa_en} = 2'b11;
            {wb_dat, wa_dat} = tmr;
          end
          dta_pkg::TIMER_PRESET_STORE: next_tmr = {dmem[wb_adr], m};
          dta_pkg::IDXM_A_IX, dta_pkg::IDXM_IX_A: begin
            next_ptr = m; // pointer is the low byte of the index word
            next_state = dta_pkg::ST_IDX2;
          end
          dta_pkg::XCH: begin
            next_acc = m;
            wa_en = 1'b1;
            wa_dat = acc;
          end
          dta_pkg::PUSHAF: begin
            wa_adr = sp[DMEM_AW-1:0];
            wb_adr = wa_adr + 1'b1;
            {wb_en, wa_en} = 2'b11;
            {wb_dat, wa_dat} = {4'h0, flag, acc};
            next_sp = sp + `SP_STEP;
          end
          dta_pkg::POPAF: begin
            next_sp = sp - `SP_STEP;
            next_acc = dmem[next_sp[DMEM_AW-1:0]];
            next_flag = dmem[next_sp[DMEM_AW-1:0] + 1'b1][3:0];
          end
          dta_pkg::CLEAR_M: begin
            wa_en = 1'b1;
            wa_dat = 8'h00;
          end
          dta_pkg::SET0_M, dta_pkg::SET1_M: begin
            // bytes above the bit window are refused
            if (oper[7:0] > `BITOP_LAST) begin
              next_err = 1'b1;
            end else begin
              wa_en = 1'b1;
              wa_dat = m;
              wa_dat[oper[18:16]] = (op == dta_pkg::SET1_M);
            end
          end
          default: begin
            // arithmetic forms
            case (op)
              dta_pkg::ADD_A_I: r = alu(acc, imm, 1'b0, 1'b0);
              dta_pkg::ADD_A_M, dta_pkg::ADD_M_A: r = alu(acc, m, 1'b0, 1'b0);
              dta_pkg::ADDC_A_M, dta_pkg::ADDC_M_A: r = alu(acc, m, flag[`FLG_C], 1'b0);
              dta_pkg::ADDC_A: r = alu(acc, 8'h00, flag[`FLG_C], 1'b0);
              dta_pkg::ADDC_M: r = alu(m, 8'h00, flag[`FLG_C], 1'b0);
              dta_pkg::NADD_A_M: r = alu(m, acc, 1'b0, 1'b1);
              dta_pkg::NADD_M_A: r = alu(acc, m, 1'b0, 1'b1);
              dta_pkg::SUB_A_I: r = alu(acc, imm, 1'b0, 1'b1);
              dta_pkg::SUB_A_M: r = alu(acc, m, 1'b0, 1'b1);
              dta_pkg::SUB_M_A: r = alu(m, acc, 1'b0, 1'b1);
              dta_pkg::SUBC_A_M: r = alu(acc, m, flag[`FLG_C], 1'b1);
              dta_pkg::SUBC_M_A: r = alu(m, acc, flag[`FLG_C], 1'b1);
              dta_pkg::SUBC_A: r = alu(acc, 8'h00, flag[`FLG_C], 1'b1);
              dta_pkg::SUBC_M: r = alu(m, 8'h00, flag[`FLG_C], 1'b1);
              dta_pkg::INC_M: r = alu(m, 8'h01, 1'b0, 1'b0);
              dta_pkg::DEC_M: r = alu(m, 8'h01, 1'b0, 1'b1);
              default: r = '0;
            endcase
            // unknown codes fall through as a no-op
            if (op <= dta_pkg::DEC_M) begin
              next_flag = {r.ov, r.ac, r.c, r.z};
              case (op)
                dta_pkg::ADD_M_A, dta_pkg::ADDC_M_A, dta_pkg::ADDC_M, dta_pkg::NADD_M_A,
                dta_pkg::SUB_M_A, dta_pkg::SUBC_M_A, dta_pkg::SUBC_M, dta_pkg::INC_M,
                dta_pkg::DEC_M: begin
                  wa_en = 1'b1;
                  wa_dat = r.res;
                end
                default: next_acc = r.res;
              endcase
            end
          end
        endcase
      end
      dta_pkg::ST_IDX2: begin
        // second cycle of the indirect move
        next_state = dta_pkg::ST_IDLE;
        wa_adr = ptr[DMEM_AW-1:0];
        if (op == dta_pkg::IDXM_A_IX) begin
          next_acc = dmem[wa_adr];
        end else begin
          wa_en = 1'b1;
          wa_dat = acc;
        end
      end
      default: next_state = dta_pkg::ST_IDLE;
    endcase
    next_busy = (next_state != dta_pkg::ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state <= dta_pkg::ST_IDLE;
      op <= dta_pkg::MOV_A_I;
      acc <= `ACC_RST;
      flag <= `FLAG_RST;
      sp <= `SP_RST;
      ptr <= 8'h00;
      tmr <= `TMR_RST;
      oper <= `OPER_RST;
      err <= 1'b0;
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
      BUSY_OUT <= 1'b0;
      FLAGS_OUT <= `FLAG_RST;
    end else begin
      state <= next_state;
      op <= next_op;
      acc <= next_acc;
      flag <= next_flag;
      sp <= next_sp;
      ptr <= next_ptr;
      tmr <= next_tmr;
      oper <= next_oper;
      err <= next_err;
      WB_ACK_OUT <= next_ack;
      WB_DAT_OUT <= next_dat;
      BUSY_OUT <= next_busy;
      FLAGS_OUT <= next_flag;
    end
  end

  // memories carry no reset; contents are undefined until written
  always_ff @(posedge MCLK_IN) begin
    if (wa_en) dmem[wa_adr] <= wa_dat;
    if (wb_en) dmem[wb_adr] <= wb_dat;
    if (io_en) iomem[io_adr] <= io_dat;
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!rst_n);

  sequence s_run(dta_pkg::op_e o);
    state == dta_pkg::ST_EXEC && op == o;
  endsequence

  property p_zero;
    s_run(dta_pkg::SUB_A_M) |=> flag[`FLG_Z] == (acc == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong after subtract");

  property p_carry;
    s_run(dta_pkg::ADD_A_I) |=> flag[`FLG_C] == ((9'($past(acc)) + 9'($past(imm))) > 9'h0FF);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong after add");

  property p_nibble;
    s_run(dta_pkg::ADD_A_I) |=> flag[`FLG_AC] == ((5'($past(acc[3:0])) + 5'($past(imm[3:0]))) > 5'h0F);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble carry wrong after add");

  property p_ovf;
    s_run(dta_pkg::ADD_A_I) ##1 ($past(acc[7]) == $past(imm[7]))
      |-> flag[`FLG_OV] == (acc[7] != $past(acc[7]));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong after add");

  property p_bitwin;
    s_run(dta_pkg::SET1_M) ##0 (oper[7:0] > `BITOP_LAST) |-> !wa_en ##1 err;
  endproperty
  a_bitwin: assert property (p_bitwin) else $error("bit op above window not refused");

  property p_load;
    s_run(dta_pkg::MOV_A_M) |=> acc == $past(m) && flag[3:1] == $past(flag[3:1]) && !BUSY_OUT;
  endproperty
  a_load: assert property (p_load) else $error("memory load wrong");

  sequence s_idx_tail;
    state == dta_pkg::ST_IDX2 ##1 state == dta_pkg::ST_IDLE;
  endsequence
  property p_idx;
    s_run(dta_pkg::IDXM_A_IX) |=> s_idx_tail ##0 $stable(flag);
  endproperty
  a_idx: assert property (p_idx) else $error("indirect move not two cycles");

  property p_push;
    s_run(dta_pkg::PUSHAF) |=> sp == $past(sp) + `SP_STEP && dmem[$past(sp)] == $past(acc);
  endproperty
  a_push: assert property (p_push) else $error("push pair wrong");

  property p_pop;
    s_run(dta_pkg::POPAF) |=> sp == $past(sp) - `SP_STEP && acc == dmem[sp];
  endproperty
  a_pop: assert property (p_pop) else $error("pop pair wrong");

endmodule : mcu_data_transfer_arith_unit

`default_nettype wire

// ==== logic/dta_defs.svh ====
// constants for the data-transfer and arithmetic datapath
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef DTA_DEFS_SVH
`define DTA_DEFS_SVH

// register byte offsets (low 12 address bits)
`define REG_CTRL 12'h000
`define REG_OPER 12'h004
`define REG_ACC 12'h008
`define REG_FLAG 12'h00C
`define REG_SP 12'h010
`define REG_TMR 12'h014
// address regions taken from adr[11:10]
`define RGN_REGS 2'h0
`define RGN_MEM 2'h1
`define RGN_IO 2'h2

// flag bit positions
`define FLG_Z 0
`define FLG_C 1
`define FLG_AC 2
`define FLG_OV 3
// control register read fields
`define CTRL_BUSY 8
`define CTRL_ERR 9

// reset values
`define ACC_RST 8'h00
`define FLAG_RST 4'h0
`define SP_RST 8'h00
`define TMR_RST 16'h0000
`define OPER_RST 19'h00000

// stack step and highest bit-addressable byte
`define SP_STEP 8'h02
`define BITOP_LAST 8'h3F
`endif

// ==== logic/dta_pkg.sv ====
// types shared by the datapath and its bench
// assumes dta_defs.svh supplies the numbers
`default_nettype none
package dta_pkg;
  // operation codes, written into the control register low bits
  typedef enum logic [5:0] {
    MOV_A_I, MOV_M_A, MOV_A_M, MOV_A_IO, MOV_IO_A, TIMER_SNAPSHOT_LOAD, TIMER_PRESET_STORE,
    IDXM_A_IX, IDXM_IX_A, XCH, PUSHAF, POPAF,
    ADD_A_I, ADD_A_M, ADD_M_A, ADDC_A_M, ADDC_M_A, ADDC_A, ADDC_M,
    NADD_A_M, NADD_M_A, SUB_A_I, SUB_A_M, SUB_M_A, SUBC_A_M, SUBC_M_A,
    SUBC_A, SUBC_M, INC_M, DEC_M, CLEAR_M, SET0_M, SET1_M
  } op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_IDX2} state_e;
  // adder result with its four flags
  typedef struct packed {
    logic [7:0] res;
    logic ov;
    logic ac;
    logic c;
    logic z;
  } alu_s;
  // one wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;
endpackage : dta_pkg
`default_nettype wire

// ==== testbench/host_wb_master.sv ====
// classic wishbone master standing in for the controller's bus host
// assumes the slave acks every request; the bench watchdog cuts a hang
`timescale 1ns/1ps
`default_nettype none

module host_wb_master (
  // clock
  input wire logic clk_in,
  // slave answer
  input wire logic ack_in,
  input wire logic [31:0] rdat_in,
  // request
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [11:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] wdat_out
);
  // idle bus from time zero
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 12'h000;
    sel_out = 4'h0;
    wdat_out = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one single cycle; released lines show inverted junk so stale data is not trusted
  task automatic bus_cycle(input logic w, input logic [11:0] a, input logic [31:0] d,
                           output logic [31:0] q);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    sel_out <= 4'hF;
    wdat_out <= d;
    do @(posedge clk_in); while (ack_in !== 1'b1);
    q = rdat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out <= ~w;
    adr_out <= ~a;
    sel_out <= 4'h0;
    wdat_out <= ~d;
  endtask : bus_cycle
endmodule : host_wb_master
`default_nettype wire

// ==== testbench/mcu_data_transfer_arith_unit_bench.sv ====
// self-checking bench for the data-transfer and arithmetic datapath
// assumes the host master model and the design's package and defines
`include "dta_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module mcu_data_transfer_arith_unit_bench;
  logic mclk, rstn, cyc, stb, we, ack, busy;
  logic [11:0] adr;
  logic [3:0] sel, flags;
  logic [31:0] wdat, rdat, ctrl_rd;
  int err_count, num_checks, busy_run, busy_len;

  // 125 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  host_wb_master u_host (.clk_in(mclk), .ack_in(ack), .rdat_in(rdat), .cyc_out(cyc), .stb_out(stb),
    .we_out(we), .adr_out(adr), .sel_out(sel), .wdat_out(wdat));
  mcu_data_transfer_arith_unit DUT (.MCLK_IN(mclk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .BUSY_OUT(busy), .FLAGS_OUT(flags));

  // length of the last busy pulse, to pin down cycle counts
  always @(posedge mclk) begin
    if (busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_flags

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.bus_cycle(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    u_host.bus_cycle(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk_val({8'h00, d[7:0]}, {8'h00, exp}, what);
  endtask : rd_chk

  // register copy and pin copy of the flags must agree
  task automatic rd_flg(input logic [3:0] exp);
    logic [31:0] d;
    rd(`REG_FLAG, d);
    chk_flags(d[3:0], exp, "flag reg");
    chk_flags(flags, exp, "flag pins");
  endtask : rd_flg

  function automatic logic [11:0] mem_adr(input logic [7:0] k);
    return {2'b01, k, 2'b00};
  endfunction : mem_adr

  // start an op, poll until idle; len 0 skips the busy-length check
  task automatic run_op(input dta_pkg::op_e op, input int len);
    int n;
    n = 0;
    busy_len = 0;
    wr(`REG_CTRL, {26'h0, op});
    do begin
      rd(`REG_CTRL, ctrl_rd);
      n++;
    end while (ctrl_rd[`CTRL_BUSY] !== 1'b0 && n < 16);
    chk_val({15'h0, ctrl_rd[`CTRL_BUSY]}, 16'h0000, "still busy");
    if (len != 0) chk_val(16'(busy_len), 16'(len), "busy cycles");
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////
  // reference: imm equals the memory byte, carry is a borrow when subtracting
  function automatic void model(input dta_pkg::op_e op, input logic [7:0] a, input logic [7:0] m,
    input logic [3:0] f, output logic [7:0] ea, output logic [7:0] em, output logic [3:0] ef);
    logic [7:0] x, y, r;
    logic ci, sub, to_m, ar;
    logic [8:0] s;
    logic [4:0] n;
    ea = a; em = m; ef = f; x = a; y = m; ci = 1'b0; sub = 1'b0; to_m = 1'b0; ar = 1'b1;
    case (op)
      dta_pkg::MOV_A_I: begin ea = m; ar = 1'b0; end
      dta_pkg::MOV_M_A: begin em = a; ar = 1'b0; end
      dta_pkg::MOV_A_M: begin ea = m; ef[`FLG_Z] = (m == 8'h00); ar = 1'b0; end
      dta_pkg::XCH: begin ea = m; em = a; ar = 1'b0; end
      dta_pkg::CLEAR_M: begin em = 8'h00; ar = 1'b0; end
      dta_pkg::ADD_M_A: to_m = 1'b1;
      dta_pkg::ADDC_A_M: ci = f[`FLG_C];
      dta_pkg::ADDC_M_A: begin ci = f[`FLG_C]; to_m = 1'b1; end
      dta_pkg::ADDC_A: begin y = 8'h00; ci = f[`FLG_C]; end
      dta_pkg::ADDC_M: begin x = m; y = 8'h00; ci = f[`FLG_C]; to_m = 1'b1; end
      dta_pkg::NADD_A_M: begin x = m; y = a; sub = 1'b1; end
      dta_pkg::NADD_M_A: begin sub = 1'b1; to_m = 1'b1; end
      dta_pkg::SUB_A_I, dta_pkg::SUB_A_M: sub = 1'b1;
      dta_pkg::SUB_M_A: begin x = m; y = a; sub = 1'b1; to_m = 1'b1; end
      dta_pkg::SUBC_A_M: begin sub = 1'b1; ci = f[`FLG_C]; end
      dta_pkg::SUBC_M_A: begin x = m; y = a; sub = 1'b1; ci = f[`FLG_C]; to_m = 1'b1; end
      dta_pkg::SUBC_A: begin y = 8'h00; sub = 1'b1; ci = f[`FLG_C]; end
      dta_pkg::SUBC_M: begin x = m; y = 8'h00; sub = 1'b1; ci = f[`FLG_C]; to_m = 1'b1; end
      dta_pkg::INC_M: begin x = m; y = 8'h01; to_m = 1'b1; end
      dta_pkg::DEC_M: begin x = m; y = 8'h01; sub = 1'b1; to_m = 1'b1; end
      default: ;
    endcase
    if (ar) begin
      s = sub ? {1'b0, x} - {1'b0, y} - {8'h00, ci} : {1'b0, x} + {1'b0, y} + {8'h00, ci};
      n = sub ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci} : {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      r = s[7:0];
      ef[`FLG_OV] = sub ? (x[7] != y[7] && r[7] != x[7]) : (x[7] == y[7] && r[7] != x[7]);
      ef[`FLG_AC] = n[4];
      ef[`FLG_C] = s[8];
      ef[`FLG_Z] = (r == 8'h00);
      if (to_m) em = r;
      else ea = r;
    end
  endfunction : model

  task automatic do_case(input dta_pkg::op_e op, input logic [7:0] a, input logic [7:0] m, input logic [3:0] f);
    logic [7:0] ea, em;
    logic [3:0] ef;
    wr(mem_adr(8'h10), {24'h0, m});
    wr(`REG_OPER, {16'h0, m, 8'h10});
    wr(`REG_ACC, {24'h0, a});
    wr(`REG_FLAG, {28'h0, f});
    run_op(op, 1);
    model(op, a, m, f, ea, em, ef);
    rd_chk(`REG_ACC, ea, "acc");
    rd_chk(mem_adr(8'h10), em, "mem");
    rd_flg(ef);
  endtask : do_case

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial begin
    dta_pkg::op_e ops[23];
    logic [7:0] av[5], mv[5];
    logic [3:0] fv[5];
    logic [31:0] d;
    logic [15:0] w;
    ops = '{dta_pkg::MOV_A_I, dta_pkg::MOV_M_A, dta_pkg::MOV_A_M, dta_pkg::XCH, dta_pkg::CLEAR_M,
      dta_pkg::ADD_A_I, dta_pkg::ADD_A_M, dta_pkg::ADD_M_A, dta_pkg::ADDC_A_M, dta_pkg::ADDC_M_A,
      dta_pkg::ADDC_A, dta_pkg::ADDC_M, dta_pkg::NADD_A_M, dta_pkg::NADD_M_A, dta_pkg::SUB_A_I,
      dta_pkg::SUB_A_M, dta_pkg::SUB_M_A, dta_pkg::SUBC_A_M, dta_pkg::SUBC_M_A, dta_pkg::SUBC_A,
      dta_pkg::SUBC_M, dta_pkg::INC_M, dta_pkg::DEC_M};
    av = '{8'h7F, 8'h00, 8'h80, 8'h0F, 8'hFF};
    mv = '{8'h01, 8'h00, 8'hFF, 8'h01, 8'h01};
    fv = '{4'h2, 4'h0, 4'hF, 4'hD, 4'h0};
    rstn = 1'b0;
    err_count = 0;
    num_checks = 0;
    busy_run = 0;
    busy_len = 0;
    repeat (5) @(posedge mclk);
    chk_val({15'h0, ack}, 16'h0000, "ack in reset");
    chk_flags(flags, 4'h0, "flags in reset");
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(`REG_ACC, 8'h00, "acc reset");
    rd_chk(`REG_SP, 8'h00, "sp reset");
    rd_flg(4'h0);
    wr(12'hC00, 32'hFFFF_FFFF);
    rd_chk(12'hC00, 8'h00, "unmapped");
    // the direct memory moves, exchange, clear and every arithmetic form over carry, zero and overflow corners
    for (int i = 0; i < 5; i++) begin
      foreach (ops[j]) do_case(ops[j], av[i], mv[i], fv[i]);
    end
    // io moves touch only the zero flag
    wr(12'h80C, 32'h0);
    wr(`REG_OPER, 32'h3);
    wr(`REG_FLAG, 32'hE);
    wr(`REG_ACC, 32'h55);
    run_op(dta_pkg::MOV_A_IO, 1);
    rd_chk(`REG_ACC, 8'h00, "io load");
    rd_flg(4'hF);
    wr(`REG_ACC, 32'h77);
    run_op(dta_pkg::MOV_IO_A, 1);
    rd_chk(12'h80C, 8'h77, "io store");
    rd_flg(4'hF);
    wr(`REG_ACC, 32'h0);
    run_op(dta_pkg::MOV_A_IO, 1);
    rd_chk(`REG_ACC, 8'h77, "io load");
    rd_flg(4'hE);
    // indirect moves through a pointer byte, two cycles each
    wr(mem_adr(8'h30), 32'h50);
    wr(mem_adr(8'h50), 32'hA5);
    wr(`REG_OPER, 32'h30);
    wr(`REG_FLAG, 32'h6);
    run_op(dta_pkg::IDXM_A_IX, 2);
    rd_chk(`REG_ACC, 8'hA5, "idx load");
    wr(`REG_ACC, 32'h3C);
    run_op(dta_pkg::IDXM_IX_A, 2);
    rd_chk(mem_adr(8'h50), 8'h3C, "idx store");
    rd_flg(4'h6);
    // push then pop with different flags in between
    wr(`REG_SP, 32'h40);
    wr(`REG_ACC, 32'h5A);
    wr(`REG_FLAG, 32'h9);
    run_op(dta_pkg::PUSHAF, 1);
    rd_chk(mem_adr(8'h40), 8'h5A, "push acc");
    rd_chk(mem_adr(8'h41), 8'h09, "push flags");
    rd_chk(`REG_SP, 8'h42, "push sp");
    wr(`REG_ACC, 32'h0);
    wr(`REG_FLAG, 32'h6);
    run_op(dta_pkg::POPAF, 1);
    rd_chk(`REG_SP, 8'h40, "pop sp");
    rd_chk(`REG_ACC, 8'h5A, "pop acc");
    rd_flg(4'h9);
    // timer runs freely, so allow a small window after the transfer
    wr(mem_adr(8'h20), 32'h34);
    wr(mem_adr(8'h21), 32'h12);
    wr(`REG_OPER, 32'h20);
    wr(`REG_FLAG, 32'h5);
    run_op(dta_pkg::TIMER_PRESET_STORE, 1);
    rd(`REG_TMR, d);
    chk_val(16'(d[15:0] - 16'h1234) >> 6, 16'h0000, "timer preset");
    wr(`REG_OPER, 32'h22);
    run_op(dta_pkg::TIMER_SNAPSHOT_LOAD, 1);
    rd(mem_adr(8'h22), d);
    w[7:0] = d[7:0];
    rd(mem_adr(8'h23), d);
    w[15:8] = d[7:0];
    rd(`REG_TMR, d);
    chk_val(16'(d[15:0] - w) >> 6, 16'h0000, "timer snapshot");
    rd_flg(4'h5);
    // bit set at the last addressable byte, refused one above it
    wr(mem_adr(8'h3F), 32'h0);
    wr(`REG_OPER, 32'h0005_003F);
    run_op(dta_pkg::SET1_M, 1);
    rd_chk(mem_adr(8'h3F), 8'h20, "bit set");
    run_op(dta_pkg::SET0_M, 1);
    rd_chk(mem_adr(8'h3F), 8'h00, "bit clear");
    wr(mem_adr(8'h40), 32'h0);
    wr(`REG_OPER, 32'h0005_0040);
    run_op(dta_pkg::SET1_M, 0);
    chk_val({15'h0, ctrl_rd[`CTRL_ERR]}, 16'h0001, "bit refuse");
    rd_chk(mem_adr(8'h40), 8'h00, "bit refused");
    finish_test();
  end
endmodule : mcu_data_transfer_arith_unit_bench
`default_nettype wire
